// ==== ixs_alu.sv ====
// arithmetic unit for the execute subset
module ixs_alu
  import ixs_pkg::*;
(
  input wire logic [5:0] op_i,
  input wire logic [7:0] file_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] lit_i,
  output logic [7:0] res_o,
  output logic null_o
);
  always_comb
  begin
    res_o = file_i;
    if (op_i == IXS_OP_INVERT)
    begin
      res_o = ~file_i; // RQ5
    end
    else if (op_i == IXS_OP_DEC || op_i == IXS_OP_DEC_SKIP)
    begin
      res_o = file_i - 8'h01; // RQ7
    end
    else if (op_i == IXS_OP_INC)
    begin
      res_o = file_i + 8'h01; // RQ10
    end
    else if (op_i == IXS_OP_XOR_FILE)
    begin
      res_o = acc_i ^ file_i; // RQ12
    end
    else if (op_i == IXS_OP_XOR_LIT)
    begin
      res_o = acc_i ^ lit_i; // RQ11
    end
    null_o = (res_o == 8'h00); // RQ13
  end
endmodule // ixs_alu

// ==== ixs_core.sv ====
// execute stage for a subset of a 14-bit instruction core
// Operation
// RQ1: port read-modify-write uses pin levels
// RQ2: timer count write clears assigned prescaler
// RQ3: pc change or true test adds idle
// RQ4: clear accumulator zeroes it, sets null
// RQ5: invert file to selected destination
// RQ6: kick watchdog clears it, sets flags
// RQ7: decrement file to selected destination
// RQ8: decrement skip null, no flags
// RQ9: jump loads literal and latch bits
// RQ10: increment file to selected destination
// RQ11: xor literal into accumulator
// RQ12: xor accumulator with file
// RQ13: null flag set when result zero
// RQ14: destination bit 7, address bits 6:0
module ixs_core
  import ixs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic file_is_port_i,
  input wire logic [7:0] port_pins_i,
  input wire logic [4:0] upper_pc_latch_i,
  input wire logic prescaler_to_timer_i,
  output logic [12:0] program_counter_o,
  output logic [6:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  output logic file_we_o,
  output logic [7:0] acc_o,
  output logic null_flag_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o,
  output logic watchdog_clear_o,
  output logic timer_prescaler_clear_o,
  output logic idle_cycle_o
);
  //////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [7:0] pins_s1_ff;
  logic [7:0] pins_s2_ff;
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_sync_ff <= 2'b00;
      pins_s1_ff <= 8'h00;
      pins_s2_ff <= 8'h00;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      pins_s1_ff <= port_pins_i;
      pins_s2_ff <= pins_s1_ff;
    end
  end
  assign rst_n = rst_sync_ff[1];
  //////////////////////////////////////////////////////////////////////
  logic [5:0] op;
  logic dest;
  logic [7:0] operand;
  logic [7:0] alu_res;
  logic alu_null;
  logic is_file_op;
  assign op = instr_i[13:8];
  assign dest = instr_i[IXS_DEST_BIT]; // RQ14
  assign file_addr_o = instr_i[6:0]; // RQ14
  // external pins, not the output latch, feed the operand of a port
  assign operand = file_is_port_i ? pins_s2_ff : file_rdata_i; // RQ1
  assign is_file_op = (op == IXS_OP_INVERT) || (op == IXS_OP_DEC) || (op == IXS_OP_DEC_SKIP)
    || (op == IXS_OP_INC) || (op == IXS_OP_XOR_FILE);
  ixs_alu u_alu (
    .op_i(op),
    .file_i(operand),
    .acc_i(acc_o),
    .lit_i(instr_i[7:0]),
    .res_o(alu_res),
    .null_o(alu_null)
  );
  //////////////////////////////////////////////////////////////////////
  ixs_state_t state_ff, nxt_state;
  logic [12:0] nxt_pc;
  logic [7:0] nxt_acc;
  logic nxt_null, nxt_to, nxt_pd;
  logic exec;
  assign exec = instr_valid_i && (state_ff == IXS_ST_RUN);
  always_comb
  begin
    nxt_state = state_ff;
    nxt_pc = program_counter_o;
    nxt_acc = acc_o;
    nxt_null = null_flag_o;
    nxt_to = timeout_flag_o;
    nxt_pd = powerdown_flag_o;
    file_we_o = 1'b0;
    file_wdata_o = alu_res;
    watchdog_clear_o = 1'b0;
    timer_prescaler_clear_o = 1'b0;
    if (state_ff == IXS_ST_IDLE)
    begin
      nxt_state = IXS_ST_RUN; // RQ3
    end
    else if (exec)
    begin
      nxt_pc = program_counter_o + 13'h0001;
      if (instr_i == IXS_OP_CLEAR_ACC)
      begin
        nxt_acc = IXS_ACC_RST; // RQ4
        nxt_null = 1'b1; // RQ4
      end
      else if (instr_i == IXS_OP_KICK_WD)
      begin
        watchdog_clear_o = 1'b1; // RQ6
        nxt_to = 1'b1; // RQ6
        nxt_pd = 1'b1; // RQ6
      end
      else if (instr_i[13:11] == IXS_OP_JUMP)
      begin
        nxt_pc = {upper_pc_latch_i[IXS_LATCH_HI:IXS_LATCH_LO],
          instr_i[IXS_JUMP_LSB_W-1:0]}; // RQ9
        nxt_state = IXS_ST_IDLE; // RQ3
      end
      else if (is_file_op || op == IXS_OP_XOR_LIT)
      begin
        if (op != IXS_OP_DEC_SKIP)
        begin
          nxt_null = alu_null; // RQ13
        end
        if (is_file_op && dest)
        begin
          file_we_o = 1'b1;
          // a write to the timer count restarts its prescaler
          timer_prescaler_clear_o = (file_addr_o == IXS_TIMER_ZERO_COUNT_ADDR)
            && prescaler_to_timer_i; // RQ2
        end
        else
        begin
          nxt_acc = alu_res;
        end
        if (op == IXS_OP_DEC_SKIP && alu_null)
        begin
          // the prefetched word is dropped, so the pc steps over it
          nxt_pc = program_counter_o + 13'h0002; // RQ8
          nxt_state = IXS_ST_IDLE; // RQ8
        end
      end
    end
  end
  assign idle_cycle_o = (state_ff == IXS_ST_IDLE);
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= IXS_ST_RUN;
      program_counter_o <= IXS_PC_RST;
      acc_o <= IXS_ACC_RST;
      null_flag_o <= 1'b0;
      timeout_flag_o <= 1'b1;
      powerdown_flag_o <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      program_counter_o <= nxt_pc;
      acc_o <= nxt_acc;
      null_flag_o <= nxt_null;
      timeout_flag_o <= nxt_to;
      powerdown_flag_o <= nxt_pd;
    end
  end
  //////////////////////////////////////////////////////////////////////
  sequence s_skip_taken;
    exec && op == IXS_OP_DEC_SKIP && alu_null;
  endsequence
  a_skip_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ8
    s_skip_taken |=> idle_cycle_o ##1 !idle_cycle_o)
    else $error("skip did not insert one idle cycle");
  a_jump_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ3
    exec && instr_i[13:11] == IXS_OP_JUMP |=> idle_cycle_o)
    else $error("jump without idle cycle");
  a_jump_target: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ9
    exec && instr_i[13:11] == IXS_OP_JUMP |=> program_counter_o
      == {$past(upper_pc_latch_i[4:3]), $past(instr_i[10:0])})
    else $error("jump target wrong");
  a_clear_acc: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ4
    exec && instr_i == IXS_OP_CLEAR_ACC |=> acc_o == 8'h00 && null_flag_o)
    else $error("clear accumulator wrong");
  a_kick_flags: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ6
    exec && instr_i == IXS_OP_KICK_WD |-> watchdog_clear_o ##1 timeout_flag_o && powerdown_flag_o)
    else $error("watchdog kick wrong");
  a_skip_flags: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ8
    exec && op == IXS_OP_DEC_SKIP |=> $stable(null_flag_o))
    else $error("skip changed null flag");
  a_null_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ13
    exec && (op == IXS_OP_INC || op == IXS_OP_XOR_LIT) |=> null_flag_o == ($past(alu_res) == 8'h00))
    else $error("null flag mismatch");
  a_tmr_presc: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ2
    timer_prescaler_clear_o |-> file_we_o && file_addr_o == IXS_TIMER_ZERO_COUNT_ADDR && prescaler_to_timer_i)
    else $error("spurious prescaler clear");
  a_inc_dest: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ10
    exec && op == IXS_OP_INC && !dest |=> acc_o == $past(operand) + 8'h01)
    else $error("increment to accumulator wrong");
  a_port_rmw: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ1
    file_we_o && file_is_port_i && op == IXS_OP_INVERT |-> file_wdata_o == ~pins_s2_ff)
    else $error("port operand not from pins");
  a_skip_pc: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ8
    s_skip_taken |=> program_counter_o == $past(program_counter_o) + 13'h0002)
    else $error("skip did not step over the fetched word");
  a_idle_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ3
    idle_cycle_o |-> !file_we_o && !watchdog_clear_o && !timer_prescaler_clear_o)
    else $error("idle cycle produced a side effect");
  a_idle_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ3
    idle_cycle_o |=> acc_o == $past(acc_o) && null_flag_o == $past(null_flag_o))
    else $error("idle cycle changed accumulator or flag");
  a_dec_dest: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ7
    exec && op == IXS_OP_DEC && !dest |=> acc_o == $past(operand) - 8'h01)
    else $error("decrement to accumulator wrong");
  a_invert_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // RQ5
    exec && op == IXS_OP_INVERT && dest |-> file_we_o && file_wdata_o == ~operand)
    else $error("invert write back wrong");
endmodule // ixs_core

// ==== ixs_file_model.sv ====
// behavioural file-register model facing the execute stage
module ixs_file_model (
  input wire logic sys_clk_i,
  input wire logic [6:0] file_addr_i,
  input wire logic [7:0] file_wdata_i,
  input wire logic file_we_i,
  output logic [7:0] file_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // unwritten places read unknown, so a stray read shows up
  logic [7:0] mem [128];
  assign file_rdata_o = mem[file_addr_i];
  always @(posedge sys_clk_i)
  begin
    if (file_we_i)
      mem[file_addr_i] <= file_wdata_i;
  end
endmodule // ixs_file_model

// ==== ixs_pkg.sv ====
// package: opcodes, field positions, reset values and addresses for the execute subset
package ixs_pkg;
  localparam logic [13:0] IXS_OP_CLEAR_ACC = 14'h0103;
  localparam logic [13:0] IXS_OP_KICK_WD = 14'h0064;
  localparam logic [5:0] IXS_OP_INVERT = 6'h09;
  localparam logic [5:0] IXS_OP_DEC = 6'h03;
  localparam logic [5:0] IXS_OP_DEC_SKIP = 6'h0b;
  localparam logic [5:0] IXS_OP_INC = 6'h0a;
  localparam logic [5:0] IXS_OP_XOR_FILE = 6'h06;
  localparam logic [5:0] IXS_OP_XOR_LIT = 6'h3a;
  localparam logic [2:0] IXS_OP_JUMP = 3'h5;
  localparam int IXS_DEST_BIT = 7;
  localparam int IXS_JUMP_LSB_W = 11;
  localparam int IXS_LATCH_HI = 4;
  localparam int IXS_LATCH_LO = 3;
  localparam logic [6:0] IXS_TIMER_ZERO_COUNT_ADDR = 7'h01;
  localparam logic [7:0] IXS_ACC_RST = 8'h00;
  localparam logic [12:0] IXS_PC_RST = 13'h0000;
  typedef enum logic [1:0] {
    IXS_ST_RUN = 2'b01,
    IXS_ST_IDLE = 2'b10
  } ixs_state_t;
endpackage

// ==== tb.sv ====
// self-checking bench for the execute subset
module tb
  import ixs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic file_is_port_i = 1'b0;
  logic [7:0] port_pins_i = 8'h0f;
  logic [4:0] upper_pc_latch_i = 5'h18;
  logic prescaler_to_timer_i = 1'b1;
  logic [7:0] file_rdata_i, file_wdata_o, acc_o, wd_s;
  logic [12:0] program_counter_o;
  logic [6:0] file_addr_o;
  logic file_we_o, null_flag_o, timeout_flag_o, powerdown_flag_o;
  logic watchdog_clear_o, timer_prescaler_clear_o, idle_cycle_o, we_s, wc_s, tp_s;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  ixs_core ixs_core_i (.sys_clk_i, .nrst_i, .instr_valid_i, .instr_i, .file_rdata_i,
    .file_is_port_i, .port_pins_i, .upper_pc_latch_i, .prescaler_to_timer_i,
    .program_counter_o, .file_addr_o, .file_wdata_o, .file_we_o, .acc_o, .null_flag_o,
    .timeout_flag_o, .powerdown_flag_o, .watchdog_clear_o, .timer_prescaler_clear_o,
    .idle_cycle_o);
  ixs_file_model ixs_file_model_i (.sys_clk_i, .file_addr_i(file_addr_o),
    .file_wdata_i(file_wdata_o), .file_we_i(file_we_o), .file_rdata_o(file_rdata_i));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // strobes are combinational, so catch them mid-cycle before the taking edge
  task automatic run(input logic [13:0] w);
    @(posedge sys_clk_i);
    instr_i <= w;
    instr_valid_i <= 1'b1;
    @(negedge sys_clk_i);
    {we_s, wd_s, wc_s, tp_s} = {file_we_o, file_wdata_o, watchdog_clear_o,
      timer_prescaler_clear_o};
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask
  // second word stands during the forced idle cycle and must be dropped
  task automatic run_pair(input logic [13:0] w1, input logic [13:0] w2);
    @(posedge sys_clk_i);
    instr_i <= w1;
    instr_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    instr_i <= w2;
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ixs_file_model_i.mem[7'h01] = 8'h00;
    ixs_file_model_i.mem[7'h20] = 8'h13;
    ixs_file_model_i.mem[7'h21] = 8'hff;
    ixs_file_model_i.mem[7'h22] = 8'hff;
    ixs_file_model_i.mem[7'h23] = 8'h02;
    ixs_file_model_i.mem[7'h24] = 8'hff;
    ixs_file_model_i.mem[7'h25] = 8'h01;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({program_counter_o, acc_o}, 16'h0000);
    chk({null_flag_o, timeout_flag_o, powerdown_flag_o, idle_cycle_o}, 16'h0006);
    run({IXS_OP_XOR_LIT, 8'hb5});
    run({IXS_OP_XOR_LIT, 8'haf});
    chk({acc_o, null_flag_o}, {8'h1a, 1'b0});
    run({IXS_OP_XOR_LIT, 8'h1a});
    chk({acc_o, null_flag_o}, {8'h00, 1'b1});
    run({IXS_OP_INVERT, 1'b0, 7'h20});
    chk({we_s, acc_o, null_flag_o}, {1'b0, 8'hec, 1'b0});
    run({IXS_OP_INVERT, 1'b1, 7'h21});
    chk({we_s, wd_s, null_flag_o, acc_o}, {1'b1, 8'h00, 1'b1, 8'hec});
    run({IXS_OP_INC, 1'b1, 7'h22});
    chk({we_s, wd_s, null_flag_o}, {1'b1, 8'h00, 1'b1});
    run({IXS_OP_DEC, 1'b0, 7'h22});
    chk({we_s, acc_o, null_flag_o}, {1'b0, 8'hff, 1'b0});
    run({IXS_OP_XOR_FILE, 1'b1, 7'h20});
    chk({we_s, wd_s, acc_o}, {1'b1, 8'hec, 8'hff});
    run(IXS_OP_CLEAR_ACC);
    chk({acc_o, null_flag_o}, {8'h00, 1'b1});
    run({IXS_OP_XOR_LIT, 8'h01});
    // flag sits at 0 so a wrong zero update by the skip would show
    run({IXS_OP_DEC_SKIP, 1'b1, 7'h23});
    chk({we_s, wd_s, idle_cycle_o, null_flag_o, program_counter_o},
      {1'b1, 8'h01, 1'b0, 1'b0, 13'h000b});
    run({IXS_OP_DEC_SKIP, 1'b1, 7'h23});
    chk({we_s, wd_s, idle_cycle_o, null_flag_o, program_counter_o},
      {1'b1, 8'h00, 1'b1, 1'b0, 13'h000d});
    run(IXS_OP_KICK_WD);
    chk({wc_s, timeout_flag_o, powerdown_flag_o}, 16'h0007);
    run({IXS_OP_INC, 1'b1, IXS_TIMER_ZERO_COUNT_ADDR});
    chk(tp_s, 16'h0001);
    run({IXS_OP_INC, 1'b0, IXS_TIMER_ZERO_COUNT_ADDR});
    chk(tp_s, 16'h0000);
    @(posedge sys_clk_i);
    prescaler_to_timer_i <= 1'b0;
    run({IXS_OP_INC, 1'b1, IXS_TIMER_ZERO_COUNT_ADDR});
    chk({we_s, tp_s}, 2'b10);
    run({IXS_OP_JUMP, 11'h5a5});
    chk({idle_cycle_o, program_counter_o}, {1'b1, 13'h1da5});
    run({IXS_OP_XOR_LIT, 8'h00});
    chk({idle_cycle_o, program_counter_o}, {1'b0, 13'h1da6});
    run_pair({IXS_OP_DEC_SKIP, 1'b1, 7'h25}, {IXS_OP_XOR_LIT, 8'hff});
    chk({idle_cycle_o, acc_o, program_counter_o}, {1'b0, 8'h02, 13'h1da8});
    @(posedge sys_clk_i);
    file_is_port_i <= 1'b1;
    run({IXS_OP_INVERT, 1'b0, 7'h24});
    chk(acc_o, 16'h00f0);
    run({IXS_OP_INVERT, 1'b1, 7'h24});
    chk({we_s, wd_s, acc_o}, {1'b1, 8'hf0, 8'hf0});
    tally_and_finish();
  end
endmodule // tb
